//--- pkg/vic_pkg.sv
package vic_pkg;

  // ---------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 3;
  localparam int PC_W        = 13;
  localparam int STACK_DEPTH = 8;
  localparam int NUM_PINS    = 4;
  localparam int NUM_VEC     = 8;
  localparam int NUM_GRP     = 3;

  // ---------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_EDGE  = 3'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL0 = 3'h1;
  localparam logic [ADDR_W-1:0] REG_CTRL1 = 3'h2;
  localparam logic [ADDR_W-1:0] REG_CTRL2 = 3'h3;
  localparam logic [ADDR_W-1:0] REG_CTM   = 3'h4;
  localparam logic [ADDR_W-1:0] REG_STM   = 3'h5;
  localparam logic [ADDR_W-1:0] REG_EELV  = 3'h6;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  // control 0
  localparam int C0_GLOBAL_EN = 0;
  localparam int C0_PIN0_EN   = 1;
  localparam int C0_PIN1_EN   = 2;
  localparam int C0_CONV_EN   = 3;
  localparam int C0_PIN0_F    = 4;
  localparam int C0_PIN1_F    = 5;
  localparam int C0_CONV_F    = 6;
  // control 1: group enables at 0..2, group flags at 4..6
  localparam int C1_GRP_EN    = 0;
  localparam int C1_PIN2_EN   = 3;
  localparam int C1_GRP_F     = 4;
  localparam int C1_PIN2_F    = 7;
  // control 2
  localparam int C2_PIN3_EN   = 0;
  localparam int C2_PIN3_F    = 4;
  // shared-group source registers: enables low nibble, flags high nibble
  localparam int SRC_EN       = 0;
  localparam int SRC_F        = 4;

  // ---------------------------------------------------------------------
  // vectors, listed in acceptance priority (index 0 first)
  // ---------------------------------------------------------------------
  localparam int VEC_PIN0 = 0;
  localparam int VEC_PIN1 = 1;
  localparam int VEC_CONV = 2;
  localparam int VEC_GRP0 = 3;
  localparam int VEC_GRP1 = 4;
  localparam int VEC_GRP2 = 5;
  localparam int VEC_PIN2 = 6;
  localparam int VEC_PIN3 = 7;

  localparam logic [PC_W-1:0] VEC_BASE = 13'h0004;
  localparam logic [PC_W-1:0] VEC_STEP = 13'h0004;

endpackage

//--- pkg/vic_edge_if.sv
`timescale 1ns/1ps
interface vic_edge_if #(
  parameter int N = vic_pkg::NUM_PINS
);
  logic [N-1:0]   pin;
  logic [N-1:0]   qual;
  logic [2*N-1:0] sel;
  logic [N-1:0]   hit;

  modport ctrl (output pin, output qual, output sel, input hit);
  modport det  (input pin, input qual, input sel, output hit);
endinterface

//--- hw/vic_edge.sv
`timescale 1ns/1ps
module vic_edge #(
  parameter int N = vic_pkg::NUM_PINS
) (
  input wire logic clk,   // system clock
  input wire logic rst_b, // async reset, active low
  vic_edge_if.det  eif    // pins, qualifiers, edge hits
);

  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] prev;
  } vic_edge_st_t;

  vic_edge_st_t s;
  vic_edge_st_t next_s;

  // ---------------------------------------------------------------------
  // synchronise, then compare against the previous settled level
  // ---------------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.sync1 = eif.pin;
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
  end

  // select bit 0 picks rising, bit 1 falling; 00 turns the pin off
  always_comb begin
    for (int i = 0; i < N; i++) begin
      eif.hit[i] = eif.qual[i] &
                   ((s.sync2[i] & ~s.prev[i] & eif.sel[2*i]) |
                    (~s.sync2[i] & s.prev[i] & eif.sel[2*i+1]));
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

//--- hw/vic_top.sv
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module vic_top #(
  parameter int PC_W        = vic_pkg::PC_W,
  parameter int STACK_DEPTH = vic_pkg::STACK_DEPTH
) (
  input  wire logic                       CLK,           // system clock
  input  wire logic                       RST_B,         // async reset
  input  wire logic [vic_pkg::ADDR_W-1:0] ADDR,          // register index
  input  wire logic [vic_pkg::DATA_W-1:0] WDATA,         // write data
  input  wire logic                       WR_STB,        // write strobe
  input  wire logic                       RD_STB,        // read strobe
  output      logic [vic_pkg::DATA_W-1:0] RDATA,         // read data
  input  wire logic [3:0]                 INT_PIN,       // external pins
  input  wire logic [3:0]                 PIN_SHARE_SEL, // pin routed here
  input  wire logic [3:0]                 PORT_DIR_IN,   // pin is input
  input  wire logic                       CONV_DONE,     // a/d finished
  input  wire logic [1:0]                 CT_A_MATCH,    // compact a match
  input  wire logic [1:0]                 CT_P_MATCH,    // compact p match
  input  wire logic                       ST_A_MATCH,    // std a match
  input  wire logic                       ST_P_MATCH,    // std p match
  input  wire logic                       EE_WRITE_DONE, // eeprom write end
  input  wire logic                       LOW_VOLTAGE,   // supply low event
  input  wire logic [PC_W-1:0]            NEXT_PC,       // next instr addr
  input  wire logic                       ACCEPT_OK,     // instr boundary
  input  wire logic                       CALL_PUSH,     // core call push
  input  wire logic                       RETURN_POP,    // return pop
  output      logic                       IRQ_PENDING,   // would accept
  output      logic                       IRQ_TAKEN,     // accepted now
  output      logic                       PC_LOAD,       // load pc pulse
  output      logic [PC_W-1:0]            PC_LOAD_ADDR,  // pc to load
  output      logic                       STACK_FULL,    // stack full
  output      logic                       WAKE           // wake pulse
);

  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);
  localparam int NV = vic_pkg::NUM_VEC;

  typedef struct packed {
    logic [7:0]                       edge_sel;
    logic                             global_irq_enable;
    logic [3:0]                       pin_request_flags;
    logic [3:0]                       pin_irq_enable;
    logic                             conversion_done_flag;
    logic                             conversion_irq_enable;
    logic [2:0]                       group_request_flag;
    logic [2:0]                       group_irq_enable;
    logic [3:0]                       ct_flag;
    logic [3:0]                       ct_enable;
    logic [1:0]                       st_flag;
    logic [1:0]                       st_enable;
    logic [1:0]                       eelv_flag;
    logic [1:0]                       eelv_enable;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [SP_W-1:0]                  sp;
    logic [vic_pkg::DATA_W-1:0]       rdata;
    logic                             pc_load;
    logic [PC_W-1:0]                  pc_load_addr;
    logic                             wake;
  } vic_state_t;

  vic_state_t s;
  vic_state_t next_s;

  logic [NV-1:0]   vec_req;
  logic [2:0]      grp_src;
  logic            any_req;
  logic [2:0]      win_idx;
  logic            take;
  logic [3:0]      ct_evt;
  logic [2:0]      grp_rise;
  logic [PC_W-1:0] vec_addr;

  // ---------------------------------------------------------------------
  // external pin edge detection
  // ---------------------------------------------------------------------
  vic_edge_if #(.N(vic_pkg::NUM_PINS)) eif ();

  assign eif.pin  = INT_PIN;
  assign eif.sel  = s.edge_sel;
  assign eif.qual = s.pin_irq_enable & PIN_SHARE_SEL & PORT_DIR_IN;

  vic_edge #(.N(vic_pkg::NUM_PINS)) u_edge (
    .clk   (CLK),
    .rst_b (RST_B),
    .eif   (eif)
  );

  // ---------------------------------------------------------------------
  // vector selection
  // ---------------------------------------------------------------------
  // compact timers: bit order {1A,1P,0A,0P}
  assign ct_evt = {CT_A_MATCH[1], CT_P_MATCH[1],
                   CT_A_MATCH[0], CT_P_MATCH[0]};

  // a group vectors only when a source inside it is itself enabled
  assign grp_src[0] = |(s.ct_flag & s.ct_enable);
  assign grp_src[1] = |(s.st_flag & s.st_enable);
  assign grp_src[2] = |(s.eelv_flag & s.eelv_enable);

  always_comb begin
    vec_req = '0;
    vec_req[vic_pkg::VEC_PIN0] = s.pin_request_flags[0] &
                                 s.pin_irq_enable[0];
    vec_req[vic_pkg::VEC_PIN1] = s.pin_request_flags[1] &
                                 s.pin_irq_enable[1];
    vec_req[vic_pkg::VEC_CONV] = s.conversion_done_flag &
                                 s.conversion_irq_enable;
    vec_req[vic_pkg::VEC_PIN2] = s.pin_request_flags[2] &
                                 s.pin_irq_enable[2];
    vec_req[vic_pkg::VEC_PIN3] = s.pin_request_flags[3] &
                                 s.pin_irq_enable[3];
    for (int g = 0; g < vic_pkg::NUM_GRP; g++) begin
      vec_req[vic_pkg::VEC_GRP0 + g] = s.group_request_flag[g] &
                                       s.group_irq_enable[g] &
                                       grp_src[g];
    end
  end

  // lowest index wins
  always_comb begin
    win_idx = '0;
    for (int v = NV - 1; v >= 0; v--) begin
      if (vec_req[v]) begin
        win_idx = 3'(v);
      end
    end
  end

  assign vec_addr = vic_pkg::VEC_BASE +
                    PC_W'(vic_pkg::VEC_STEP * PC_W'(win_idx));

  assign any_req     = |vec_req;
  assign STACK_FULL  = (s.sp == SP_FULL);
  assign IRQ_PENDING = any_req & s.global_irq_enable &
                       ~STACK_FULL;
  // the core's own push or pop owns the stack this cycle
  assign take        = IRQ_PENDING & ACCEPT_OK & ~CALL_PUSH & ~RETURN_POP;
  assign IRQ_TAKEN   = take;

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    next_s         = s;
    next_s.pc_load = 1'b0;
    next_s.rdata   = vic_pkg::REG_RESET;

    // software writes; hardware sets further down win over a written 0
    if (WR_STB) begin
      unique case (ADDR)
        vic_pkg::REG_EDGE: begin
          next_s.edge_sel = WDATA;
        end
        vic_pkg::REG_CTRL0: begin
          next_s.global_irq_enable     = WDATA[vic_pkg::C0_GLOBAL_EN];
          next_s.pin_irq_enable[0]     = WDATA[vic_pkg::C0_PIN0_EN];
          next_s.pin_irq_enable[1]     = WDATA[vic_pkg::C0_PIN1_EN];
          next_s.conversion_irq_enable = WDATA[vic_pkg::C0_CONV_EN];
          next_s.pin_request_flags[0]  = WDATA[vic_pkg::C0_PIN0_F];
          next_s.pin_request_flags[1]  = WDATA[vic_pkg::C0_PIN1_F];
          next_s.conversion_done_flag  = WDATA[vic_pkg::C0_CONV_F];
        end
        vic_pkg::REG_CTRL1: begin
          next_s.group_irq_enable     = WDATA[vic_pkg::C1_GRP_EN +: 3];
          next_s.pin_irq_enable[2]    = WDATA[vic_pkg::C1_PIN2_EN];
          next_s.group_request_flag   = WDATA[vic_pkg::C1_GRP_F +: 3];
          next_s.pin_request_flags[2] = WDATA[vic_pkg::C1_PIN2_F];
        end
        vic_pkg::REG_CTRL2: begin
          next_s.pin_irq_enable[3]    = WDATA[vic_pkg::C2_PIN3_EN];
          next_s.pin_request_flags[3] = WDATA[vic_pkg::C2_PIN3_F];
        end
        vic_pkg::REG_CTM: begin
          next_s.ct_enable = WDATA[vic_pkg::SRC_EN +: 4];
          next_s.ct_flag   = WDATA[vic_pkg::SRC_F +: 4];
        end
        vic_pkg::REG_STM: begin
          next_s.st_enable = WDATA[vic_pkg::SRC_EN +: 2];
          next_s.st_flag   = WDATA[vic_pkg::SRC_F +: 2];
        end
        vic_pkg::REG_EELV: begin
          next_s.eelv_enable = WDATA[vic_pkg::SRC_EN +: 2];
          next_s.eelv_flag   = WDATA[vic_pkg::SRC_F +: 2];
        end
        default: begin
        end
      endcase
    end

    // accepting: push, jump, drop global enable and the vector's own flag
    if (take) begin
      next_s.stack[s.sp[SP_W-1:0]] = NEXT_PC;
      next_s.sp                    = s.sp + 1'b1;
      next_s.pc_load               = 1'b1;
      next_s.pc_load_addr          = vec_addr;
      next_s.global_irq_enable     = 1'b0;
      unique case (win_idx)
        3'(vic_pkg::VEC_PIN0): next_s.pin_request_flags[0] = 1'b0;
        3'(vic_pkg::VEC_PIN1): next_s.pin_request_flags[1] = 1'b0;
        3'(vic_pkg::VEC_CONV): next_s.conversion_done_flag = 1'b0;
        3'(vic_pkg::VEC_GRP0): next_s.group_request_flag[0] = 1'b0;
        3'(vic_pkg::VEC_GRP1): next_s.group_request_flag[1] = 1'b0;
        3'(vic_pkg::VEC_GRP2): next_s.group_request_flag[2] = 1'b0;
        3'(vic_pkg::VEC_PIN2): next_s.pin_request_flags[2] = 1'b0;
        3'(vic_pkg::VEC_PIN3): next_s.pin_request_flags[3] = 1'b0;
      endcase
    end else if (CALL_PUSH && !STACK_FULL) begin
      // a call on a full stack is dropped; the core must avoid it
      next_s.stack[s.sp[SP_W-1:0]] = NEXT_PC;
      next_s.sp                    = s.sp + 1'b1;
    end else if (RETURN_POP && s.sp != '0) begin
      next_s.sp           = s.sp - 1'b1;
      next_s.pc_load      = 1'b1;
      next_s.pc_load_addr = s.stack[s.sp - 1'b1];
    end

    // hardware sets last so a same-cycle clear never loses an event
    next_s.pin_request_flags = next_s.pin_request_flags | eif.hit;
    next_s.conversion_done_flag = next_s.conversion_done_flag |
                                  CONV_DONE;
    next_s.ct_flag   = next_s.ct_flag | ct_evt;
    next_s.st_flag   = next_s.st_flag |
                       {ST_A_MATCH, ST_P_MATCH};
    next_s.eelv_flag = next_s.eelv_flag |
                       {EE_WRITE_DONE, LOW_VOLTAGE};

    // a group flag follows a source flag turning on, not its level,
    // otherwise a still-set source would re-arm the group at once
    grp_rise[0] = |(next_s.ct_flag & ~s.ct_flag);
    grp_rise[1] = |(next_s.st_flag & ~s.st_flag);
    grp_rise[2] = |(next_s.eelv_flag & ~s.eelv_flag);
    next_s.group_request_flag = next_s.group_request_flag |
                                grp_rise;

    // wake on any flag going high, enables play no part
    next_s.wake =
      |(next_s.pin_request_flags & ~s.pin_request_flags) |
      (next_s.conversion_done_flag & ~s.conversion_done_flag) |
      |(next_s.group_request_flag & ~s.group_request_flag) |
      |grp_rise;

    // read data from the pre-write state, shown in the next cycle
    if (RD_STB) begin
      unique case (ADDR)
        vic_pkg::REG_EDGE: begin
          next_s.rdata = s.edge_sel;
        end
        vic_pkg::REG_CTRL0: begin
          next_s.rdata[vic_pkg::C0_GLOBAL_EN] = s.global_irq_enable;
          next_s.rdata[vic_pkg::C0_PIN0_EN]   = s.pin_irq_enable[0];
          next_s.rdata[vic_pkg::C0_PIN1_EN]   = s.pin_irq_enable[1];
          next_s.rdata[vic_pkg::C0_CONV_EN]   = s.conversion_irq_enable;
          next_s.rdata[vic_pkg::C0_PIN0_F]    = s.pin_request_flags[0];
          next_s.rdata[vic_pkg::C0_PIN1_F]    = s.pin_request_flags[1];
          next_s.rdata[vic_pkg::C0_CONV_F]    = s.conversion_done_flag;
        end
        vic_pkg::REG_CTRL1: begin
          next_s.rdata[vic_pkg::C1_GRP_EN +: 3] = s.group_irq_enable;
          next_s.rdata[vic_pkg::C1_PIN2_EN]     = s.pin_irq_enable[2];
          next_s.rdata[vic_pkg::C1_GRP_F +: 3]  = s.group_request_flag;
          next_s.rdata[vic_pkg::C1_PIN2_F]      = s.pin_request_flags[2];
        end
        vic_pkg::REG_CTRL2: begin
          next_s.rdata[vic_pkg::C2_PIN3_EN] = s.pin_irq_enable[3];
          next_s.rdata[vic_pkg::C2_PIN3_F]  = s.pin_request_flags[3];
        end
        vic_pkg::REG_CTM: begin
          next_s.rdata[vic_pkg::SRC_EN +: 4] = s.ct_enable;
          next_s.rdata[vic_pkg::SRC_F +: 4]  = s.ct_flag;
        end
        vic_pkg::REG_STM: begin
          next_s.rdata[vic_pkg::SRC_EN +: 2] = s.st_enable;
          next_s.rdata[vic_pkg::SRC_F +: 2]  = s.st_flag;
        end
        vic_pkg::REG_EELV: begin
          next_s.rdata[vic_pkg::SRC_EN +: 2] = s.eelv_enable;
          next_s.rdata[vic_pkg::SRC_F +: 2]  = s.eelv_flag;
        end
        default: begin
          next_s.rdata = vic_pkg::REG_RESET;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign RDATA        = s.rdata;
  assign PC_LOAD      = s.pc_load;
  assign PC_LOAD_ADDR = s.pc_load_addr;
  assign WAKE         = s.wake;

endmodule

//--- test/vic_properties.sv
`timescale 1ns/1ps
module vic_properties #(
  parameter int PC_W        = vic_pkg::PC_W,
  parameter int STACK_DEPTH = vic_pkg::STACK_DEPTH
) (
  input wire logic                       CLK,          // clock
  input wire logic                       RST_B,        // reset
  input wire logic [vic_pkg::ADDR_W-1:0] ADDR,         // index
  input wire logic                       WR_STB,       // write
  input wire logic                       RD_STB,       // read
  input wire logic [vic_pkg::DATA_W-1:0] RDATA,        // rdata
  input wire logic                       ACCEPT_OK,    // boundary
  input wire logic                       CALL_PUSH,    // call
  input wire logic                       RETURN_POP,   // return
  input wire logic                       IRQ_PENDING,  // pending
  input wire logic                       IRQ_TAKEN,    // taken
  input wire logic                       PC_LOAD,      // load
  input wire logic [PC_W-1:0]            PC_LOAD_ADDR, // load addr
  input wire logic                       STACK_FULL    // full
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // last vector sits seven steps above the base
  localparam logic [PC_W-1:0] VEC_LAST = vic_pkg::VEC_BASE + 13'h001c;

  property p_taken_load; IRQ_TAKEN |=> PC_LOAD; endproperty
  property p_take_iff;
    IRQ_TAKEN == (IRQ_PENDING && ACCEPT_OK && !CALL_PUSH && !RETURN_POP);
  endproperty
  property p_full_block; STACK_FULL |-> !IRQ_PENDING; endproperty
  property p_glob_clear; IRQ_TAKEN && !WR_STB |=> !IRQ_PENDING; endproperty
  property p_load_cause;
    PC_LOAD |-> $past(IRQ_TAKEN) || $past(RETURN_POP);
  endproperty
  property p_addr_hold; !PC_LOAD |-> $stable(PC_LOAD_ADDR); endproperty
  property p_vec_range;
    IRQ_TAKEN |=> PC_LOAD_ADDR[1:0] == 2'h0 &&
      PC_LOAD_ADDR >= vic_pkg::VEC_BASE && PC_LOAD_ADDR <= VEC_LAST;
  endproperty
  property p_stm_rsvd;
    RD_STB && ADDR == vic_pkg::REG_STM |=> (RDATA & 8'hcc) == 8'h00;
  endproperty
  property p_eelv_rsvd;
    RD_STB && ADDR == vic_pkg::REG_EELV |=> (RDATA & 8'hcc) == 8'h00;
  endproperty

  a_taken_load: assert property (p_taken_load)
    else $error("accept without pc load");
  a_take_iff: assert property (p_take_iff)
    else $error("accept strobe disagrees with its causes");
  a_full_block: assert property (p_full_block)
    else $error("pending while stack full");
  a_glob_clear: assert property (p_glob_clear)
    else $error("pending right after accept");
  a_load_cause: assert property (p_load_cause)
    else $error("pc load without accept or return");
  a_addr_hold: assert property (p_addr_hold)
    else $error("load address moved without load");
  a_vec_range: assert property (p_vec_range)
    else $error("accept loaded a non-vector address");
  a_stm_rsvd: assert property (p_stm_rsvd)
    else $error("timer register reserved bits set");
  a_eelv_rsvd: assert property (p_eelv_rsvd)
    else $error("eeprom register reserved bits set");

  c_take: cover property (IRQ_TAKEN);
  c_ret: cover property (RETURN_POP ##1 PC_LOAD);
  c_full: cover property (STACK_FULL);
endmodule

bind vic_top vic_properties #(.PC_W(PC_W), .STACK_DEPTH(STACK_DEPTH))
  u_props (.*);

//--- test/vic_core_model.sv
`timescale 1ns/1ps
module vic_core_model (
  input  wire logic        clk,        // system clock
  input  wire logic        rst_b,      // reset, active low
  input  wire logic        irq_taken,  // design accepted
  input  wire logic        push_req,   // bench asks a call
  input  wire logic        ret_req,    // bench asks a return
  input  wire logic        stall,      // hold off acceptance
  output      logic [12:0] next_pc,    // next instruction address
  output      logic        accept_ok,  // at instruction boundary
  output      logic        call_push,  // call pulse
  output      logic        return_pop, // return pulse
  output      logic [12:0] ret_pc      // address a return must load
);
  // ---------------------------------------------------------------
  // sequencer and shadow stack
  // ---------------------------------------------------------------
  logic [12:0] stk[$];
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      next_pc <= 13'h0100;
      accept_ok <= 1'b0;
      call_push <= 1'b0;
      return_pop <= 1'b0;
      ret_pc <= 13'h0000;
      stk.delete();
    end else begin
      next_pc <= next_pc + 13'h0001;
      accept_ok <= !stall;
      call_push <= push_req;
      return_pop <= ret_req;
      // pushes past the eighth entry are lost, as in the core
      if (irq_taken || (call_push && stk.size() < 8))
        stk.push_back(next_pc);
      if (return_pop && stk.size() > 0)
        ret_pc <= stk.pop_back();
    end
  end
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  logic CLK = 1'b0, RST_B = 1'b0, WR_STB = 1'b0, RD_STB = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WDATA = 8'h00, RDATA;
  logic [3:0] INT_PIN = 4'h0, PIN_SHARE_SEL = 4'hf, PORT_DIR_IN = 4'hf;
  logic CONV_DONE = 1'b0, ST_A_MATCH = 1'b0, ST_P_MATCH = 1'b0;
  logic EE_WRITE_DONE = 1'b0, LOW_VOLTAGE = 1'b0;
  logic [1:0] CT_A_MATCH = 2'h0, CT_P_MATCH = 2'h0;
  logic [12:0] NEXT_PC, PC_LOAD_ADDR;
  logic ACCEPT_OK, CALL_PUSH, RETURN_POP, IRQ_PENDING, IRQ_TAKEN;
  logic PC_LOAD, STACK_FULL, WAKE;
  logic push_req = 1'b0, ret_req = 1'b0, stall = 1'b0;
  logic [7:0] d;
  int num_errors = 0, compares = 0, c;
  // addr, write value, read-back value
  logic [18:0] rows [14] = '{
    {3'h0,8'hff,8'hff}, {3'h0,8'h00,8'h00}, {3'h1,8'hfe,8'h7e},
    {3'h1,8'h00,8'h00}, {3'h2,8'hff,8'hff}, {3'h2,8'h00,8'h00},
    {3'h3,8'hff,8'h11}, {3'h3,8'h00,8'h00}, {3'h4,8'hff,8'hff},
    {3'h4,8'h00,8'h00}, {3'h5,8'hff,8'h33}, {3'h5,8'h00,8'h00},
    {3'h6,8'hff,8'h33}, {3'h7,8'hff,8'h00}};
  always #5 CLK = ~CLK;
  vic_top DUT (.*);
  vic_core_model u_core (.clk(CLK), .rst_b(RST_B), .irq_taken(IRQ_TAKEN),
    .push_req(push_req), .ret_req(ret_req), .stall(stall),
    .next_pc(NEXT_PC), .accept_ok(ACCEPT_OK), .call_push(CALL_PUSH),
    .return_pop(RETURN_POP), .ret_pc());
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [12:0] vaddr(input int i);
    return 13'(vic_pkg::VEC_BASE + vic_pkg::VEC_STEP * i);
  endfunction
  task automatic tally_and_finish;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string w, input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge CLK); ADDR <= a; WDATA <= v; WR_STB <= 1'b1;
    @(posedge CLK); WR_STB <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge CLK); ADDR <= a; RD_STB <= 1'b1;
    @(posedge CLK); RD_STB <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    check("register", d, e);
  endtask
  // event mask: conv, ct a[1:0], ct p[1:0], st a, st p, eeprom, supply
  task automatic ev(input logic [8:0] m);
    @(posedge CLK);
    {CONV_DONE, CT_A_MATCH, CT_P_MATCH, ST_A_MATCH, ST_P_MATCH,
     EE_WRITE_DONE, LOW_VOLTAGE} <= m;
    @(posedge CLK);
    {CONV_DONE, CT_A_MATCH, CT_P_MATCH, ST_A_MATCH, ST_P_MATCH,
     EE_WRITE_DONE, LOW_VOLTAGE} <= 9'h000;
  endtask
  task automatic wake_n(input logic [8:0] m, input int e);
    int n;
    n = 0;
    ev(m);
    repeat (3) begin
      #1 if (WAKE === 1'b1) n++;
      @(posedge CLK);
    end
    check("wake count", 16'(n), 16'(e));
  endtask
  // from_core compares against the model's popped address
  task automatic wait_load(input logic [12:0] e, input bit from_core);
    int i;
    i = 0;
    do begin
      @(posedge CLK);
      #1 i++;
    end while (PC_LOAD !== 1'b1 && i < 20);
    if (i >= 20) begin
      num_errors++;
      tally_and_finish();
    end
    check("pc load", PC_LOAD_ADDR, from_core ? u_core.ret_pc : e);
  endtask
  task automatic ret;
    @(posedge CLK) ret_req <= 1'b1;
    @(posedge CLK) ret_req <= 1'b0;
    wait_load(13'h0000, 1'b1);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge CLK);
    RST_B <= 1'b1;
    for (c = 0; c < 8; c++) rchk(c[2:0], 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][18:16], rows[i][15:8]);
      rchk(rows[i][18:16], rows[i][7:0]);
    end
    wr(6, 8'h00);
    wr(2, 8'h00);
    ev(9'h008);
    repeat (4) @(posedge CLK);
    rchk(5, 8'h20);
    rchk(2, 8'h20);
    wr(5, 8'h22);
    wr(2, 8'h22);
    #1 check("pending", IRQ_PENDING, 1'b0);
    @(posedge CLK) stall <= 1'b1;
    wr(1, 8'h01);
    repeat (3) @(posedge CLK);
    #1 check("pending", {IRQ_PENDING, PC_LOAD}, 2'b10);
    @(posedge CLK) stall <= 1'b0;
    wait_load(vaddr(vic_pkg::VEC_GRP1), 1'b0);
    rchk(1, 8'h00);
    rchk(2, 8'h02);
    ev(9'h004);
    rchk(5, 8'h32);
    ret();
    wr(5, 8'h00);
    wr(2, 8'h00);
    wr(0, 8'h01);
    wr(1, 8'h0a);
    @(posedge CLK) INT_PIN <= 4'h1;
    repeat (6) @(posedge CLK);
    ev(9'h100);
    rchk(1, 8'h5a);
    wr(1, 8'h5b);
    wait_load(vaddr(vic_pkg::VEC_PIN0), 1'b0);
    rchk(1, 8'h4a);
    ret();
    wr(1, 8'h4b);
    wait_load(vaddr(vic_pkg::VEC_CONV), 1'b0);
    rchk(1, 8'h0a);
    ret();
    @(posedge CLK) INT_PIN <= 4'h0;
    repeat (6) @(posedge CLK);
    wr(1, 8'h04);
    // codes 0..3, then both edges with share off, then with output dir
    for (c = 0; c < 6; c++) begin
      wr(0, {4'h0, (c > 3) ? 2'h3 : c[1:0], 2'h0});
      @(posedge CLK) begin
        PIN_SHARE_SEL <= {2'h3, c != 4, 1'b1};
        PORT_DIR_IN <= {2'h3, c != 5, 1'b1};
        INT_PIN <= 4'h2;
      end
      repeat (6) @(posedge CLK);
      rd(1);
      check("rise flag", d[5], (c == 1 || c == 3));
      wr(1, 8'h04);
      @(posedge CLK) INT_PIN <= 4'h0;
      repeat (6) @(posedge CLK);
      rd(1);
      check("fall flag", d[5], (c == 2 || c == 3));
      wr(1, 8'h04);
    end
    wr(1, 8'h08);
    ev(9'h100);
    repeat (8) begin
      @(posedge CLK) push_req <= 1'b1;
      @(posedge CLK) push_req <= 1'b0;
    end
    wr(1, 8'h49);
    repeat (3) @(posedge CLK);
    #1 check("full gate", {STACK_FULL, IRQ_PENDING}, 2'b10);
    ret();
    wait_load(vaddr(vic_pkg::VEC_CONV), 1'b0);
    wake_n(9'h001, 1);
    rchk(6, 8'h10);
    wake_n(9'h001, 0);
    ev(9'h0f6);
    rchk(4, 8'hf0);
    rchk(5, 8'h10);
    rchk(6, 8'h30);
    tally_and_finish();
  end
endmodule
